// ==== logic/lse_params.svh ====
`ifndef LSE_PARAMS_SVH
`define LSE_PARAMS_SVH
// ****************************************
// register map
// ****************************************
`define LSE_OFS_B1_DLY 8'h24
`define LSE_OFS_PG_MASK 8'h25
`define LSE_OFS_PIN_PG 8'h26
`define LSE_RST_B1_DLY 8'h00
`define LSE_RST_PG_MASK 8'h00
`define LSE_RST_PIN_PG 8'h00
// ****************************************
// field positions
// ****************************************
`define LSE_RISE_LSB 0
`define LSE_FALL_LSB 3
`define LSE_MASK_LDO3_BIT 0
`define LSE_MASK_B1_BIT 1
`define LSE_SRC_LSB 2
`define LSE_PGSEL_LSB 5
// ****************************************
// timing
// ****************************************
`define LSE_CLK_HZ 50000000
`define LSE_TICK_MS 1
`define LSE_TICK_CYC (`LSE_CLK_HZ / 1000 * `LSE_TICK_MS)
`define LSE_DLY1_MS 7'h02
`define LSE_DLY2_MS 7'h04
`define LSE_DLY3_MS 7'h08
`define LSE_DLY4_MS 7'h10
`define LSE_DLY5_MS 7'h18
`define LSE_DLY6_MS 7'h20
`define LSE_DLY7_MS 7'h40
`endif

// ==== logic/lse_pkg.sv ====
package lse_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WDAT, ST_RDAT} lse_i2c_st_t;

   typedef struct packed {
      logic [7:0] rails; // ldo2, switch a1, step-down 6..1
      logic b1;
      logic ldo3;
   } lse_pg_t;

   typedef struct packed {
      logic scl_s1, scl_s2, scl_s3;
      logic sda_s1, sda_s2, sda_s3;
      logic [5:0] ctl_s1, ctl_s2;
      lse_pg_t pg_s1, pg_s2;
      lse_i2c_st_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic rw;
      logic oe_n;
      logic [7:0] b1_dly;
      logic [7:0] mask;
      logic [7:0] pin;
      logic b1_raw;
      logic [16:0] pre;
      logic [6:0] ms;
      logic b1_en;
      logic paired_en;
      logic ldo1_en;
      logic swb2_en;
      logic [1:0] pg_sel;
   } lse_state_t;
endpackage

// ==== logic/lse_top.sv ====
`timescale 1ns/100ps
`include "lse_params.svh"
// What this block does
// - falling edge of b1 enable delayed by code
// - rising edge of b1 enable delayed by code
// - select code picks paired rail control input
// - code 111 forces paired source high
// - eight rail power-good bits, zero includes
// - b1 and ldo3 power-good mask bits
// - two-bit paired power-good threshold select
// - swap exchanges paired and ldo1 enable logic
module lse_top #(
   parameter logic [6:0] DEV_ADDR = 7'h10, // arbitrary bus address
   parameter int CYC_PER_MS = `LSE_TICK_CYC
) (
   input wire logic CLK_I, // 50 MHz clock
   input wire logic SRST_I, // sync reset, high
   input wire logic SCL_I, // serial clock pin
   input wire logic SDA_I, // serial data pin in
   output logic SDA_OE_N_O, // data pin pull-low, low drives
   input wire logic [5:0] CTL_I, // control inputs 6..1
   input wire lse_pkg::lse_pg_t PG_I, // power-good pins
   input wire logic B1_SEL_EN_I, // b1 selected enable
   input wire logic B1_PG_OK_I, // b1 unmasked goods ok
   input wire logic LDO1_LOGIC_EN_I, // ldo1 own enable logic
   input wire logic SWAP_I, // enable logic swap
   output logic B1_EN_O, // b1 switch enable
   output logic SWB2_EN_O, // second switch enable
   output logic LDO1_EN_O, // ldo1 enable
   output logic [1:0] PAIRED_PG_SEL_O // paired pg threshold
);
   import lse_pkg::*;

   lse_state_t q, d;
   logic rise, fall, start, stop, src, ok;
   logic [6:0] dly;

   function automatic logic [6:0] dly_ms(input logic [2:0] code);
      unique case (code)
         3'h0: dly_ms = 7'h00;
         3'h1: dly_ms = `LSE_DLY1_MS;
         3'h2: dly_ms = `LSE_DLY2_MS;
         3'h3: dly_ms = `LSE_DLY3_MS;
         3'h4: dly_ms = `LSE_DLY4_MS;
         3'h5: dly_ms = `LSE_DLY5_MS;
         3'h6: dly_ms = `LSE_DLY6_MS;
         3'h7: dly_ms = `LSE_DLY7_MS;
      endcase
   endfunction

   function automatic logic pin_src(input logic [2:0] sel, input logic [5:0] c);
      unique case (sel)
         3'h0: pin_src = c[0];
         3'h1: pin_src = c[1];
         3'h2: pin_src = c[4];
         3'h3: pin_src = c[3];
         3'h4: pin_src = c[2];
         3'h5: pin_src = c[2] & c[3];
         3'h6: pin_src = c[5];
         3'h7: pin_src = 1'b1;
      endcase
   endfunction

   function automatic logic [7:0] rd_reg(input lse_state_t s, input logic [7:0] a);
      unique case (a)
         `LSE_OFS_B1_DLY: rd_reg = s.b1_dly;
         `LSE_OFS_PG_MASK: rd_reg = s.mask;
         `LSE_OFS_PIN_PG: rd_reg = s.pin;
         default: rd_reg = 8'h00;
      endcase
   endfunction

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      d = q;
      d.scl_s1 = SCL_I;
      d.scl_s2 = q.scl_s1;
      d.scl_s3 = q.scl_s2;
      d.sda_s1 = SDA_I;
      d.sda_s2 = q.sda_s1;
      d.sda_s3 = q.sda_s2;
      d.ctl_s1 = CTL_I;
      d.ctl_s2 = q.ctl_s1;
      d.pg_s1 = PG_I;
      d.pg_s2 = q.pg_s1;
      rise = q.scl_s2 & ~q.scl_s3;
      fall = ~q.scl_s2 & q.scl_s3;
      start = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
      stop = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;

      // ****************************************
      // serial register port
      // ****************************************
      if (start) begin
         d.st = ST_ADDR;
         d.cnt = 4'h0;
         d.oe_n = 1'b1;
      end else if (stop) begin
         d.st = ST_IDLE;
         d.oe_n = 1'b1;
      end else if (q.st != ST_IDLE && rise) begin
         if (q.cnt < 4'h8) begin
            d.cnt = q.cnt + 4'h1;
            if (q.st != ST_RDAT) begin
               d.sh = {q.sh[6:0], q.sda_s2};
            end
         end else if (q.cnt == 4'h8) begin
            d.cnt = 4'h9;
            if (q.st == ST_RDAT) begin
               // master nack ends the read burst
               if (q.sda_s2) begin
                  d.st = ST_IDLE;
               end else begin
                  d.ptr = q.ptr + 8'h01;
               end
            end
         end
      end else if (q.st != ST_IDLE && fall) begin
         if (q.cnt == 4'h8) begin
            d.oe_n = 1'b0;
            unique case (q.st)
               ST_IDLE: d.oe_n = 1'b1;
               ST_ADDR: begin
                  if (q.sh[7:1] != DEV_ADDR) begin
                     d.st = ST_IDLE;
                     d.oe_n = 1'b1;
                  end else begin
                     d.rw = q.sh[0];
                  end
               end
               ST_PTR: d.ptr = q.sh;
               ST_WDAT: begin
                  unique case (q.ptr)
                     `LSE_OFS_B1_DLY: d.b1_dly = q.sh;
                     `LSE_OFS_PG_MASK: d.mask = q.sh;
                     `LSE_OFS_PIN_PG: d.pin = q.sh;
                     default: d.ptr = q.ptr + 8'h01; // unmapped: data dropped
                  endcase
                  d.ptr = q.ptr + 8'h01;
               end
               ST_RDAT: d.oe_n = 1'b1;
            endcase
         end else if (q.cnt == 4'h9) begin
            d.oe_n = 1'b1;
            d.cnt = 4'h0;
            if (q.st == ST_ADDR) begin
               d.st = q.rw ? ST_RDAT : ST_PTR;
            end else if (q.st == ST_PTR) begin
               d.st = ST_WDAT;
            end
            if (d.st == ST_RDAT) begin
               d.sh = rd_reg(q, d.ptr);
               d.oe_n = d.sh[7];
            end
         end else if (q.st == ST_RDAT && q.cnt != 4'h0) begin
            d.sh = {q.sh[6:0], 1'b0};
            d.oe_n = d.sh[7];
         end
      end

      // ****************************************
      // b1 edge delay
      // ****************************************
      // prescaler restarts on each mismatch so delays are not short by a tick
      dly = B1_SEL_EN_I ? dly_ms(q.b1_dly[`LSE_RISE_LSB +: 3])
                        : dly_ms(q.b1_dly[`LSE_FALL_LSB +: 3]);
      if (B1_SEL_EN_I == q.b1_raw) begin
         d.pre = 17'h00000;
         d.ms = 7'h00;
      end else if (dly == 7'h00 || q.ms == dly) begin
         d.b1_raw = B1_SEL_EN_I;
         d.pre = 17'h00000;
         d.ms = 7'h00;
      end else if (q.pre == 17'(CYC_PER_MS - 1)) begin
         d.pre = 17'h00000;
         d.ms = q.ms + 7'h01;
      end else begin
         d.pre = q.pre + 17'h00001;
      end
      d.b1_en = d.b1_raw & B1_PG_OK_I;

      // ****************************************
      // paired rail enable
      // ****************************************
      src = pin_src(q.pin[`LSE_SRC_LSB +: 3], q.ctl_s2);
      ok = (&(q.pg_s2.rails | q.mask))
         & (q.pg_s2.b1 | q.pin[`LSE_MASK_B1_BIT])
         & (q.pg_s2.ldo3 | q.pin[`LSE_MASK_LDO3_BIT]);
      d.paired_en = src & ok;
      d.ldo1_en = SWAP_I ? q.paired_en : LDO1_LOGIC_EN_I;
      d.swb2_en = SWAP_I ? LDO1_LOGIC_EN_I : q.paired_en;
      d.pg_sel = q.pin[`LSE_PGSEL_LSB +: 2];
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         q <= '0;
         q.oe_n <= 1'b1;
         q.b1_dly <= `LSE_RST_B1_DLY;
         q.mask <= `LSE_RST_PG_MASK;
         q.pin <= `LSE_RST_PIN_PG;
      end else begin
         q <= d;
      end
   end

   assign SDA_OE_N_O = q.oe_n;
   assign B1_EN_O = q.b1_en;
   assign SWB2_EN_O = q.swb2_en;
   assign LDO1_EN_O = q.ldo1_en;
   assign PAIRED_PG_SEL_O = q.pg_sel;

   // ****************************************
   // checks
   // ****************************************
   sequence s_b1_drop;
      q.b1_raw && !B1_SEL_EN_I && q.b1_dly[5:3] != 3'h0 && q.ms == 7'h00;
   endsequence

   property p_b1_fall_hold;
      @(posedge CLK_I) disable iff (SRST_I) s_b1_drop |=> q.b1_raw;
   endproperty
   a_b1_fall_hold: assert property (p_b1_fall_hold) else $error("b1 fell early");

   property p_b1_fall_now;
      @(posedge CLK_I) disable iff (SRST_I)
         (q.b1_dly[5:3] == 3'h0 && !B1_SEL_EN_I) |=> !B1_EN_O;
   endproperty
   a_b1_fall_now: assert property (p_b1_fall_now) else $error("b1 fall not immediate");

   property p_b1_rise_now;
      @(posedge CLK_I) disable iff (SRST_I)
         (q.b1_dly[2:0] == 3'h0 && B1_SEL_EN_I && B1_PG_OK_I) |=> B1_EN_O;
   endproperty
   a_b1_rise_now: assert property (p_b1_rise_now) else $error("b1 rise not immediate");

   property p_src_and;
      @(posedge CLK_I) disable iff (SRST_I)
         (q.pin[4:2] == 3'h5 && !(q.ctl_s2[2] && q.ctl_s2[3])) |=> !q.paired_en;
   endproperty
   a_src_and: assert property (p_src_and) else $error("paired on without both inputs");

   property p_src_one;
      @(posedge CLK_I) disable iff (SRST_I)
         (q.pin[4:2] == 3'h7 && ok) |=> q.paired_en ##1 SWB2_EN_O || $past(SWAP_I);
   endproperty
   a_src_one: assert property (p_src_one) else $error("forced source not enabling");

   property p_rail_mask;
      @(posedge CLK_I) disable iff (SRST_I) (|(~q.pg_s2.rails & ~q.mask)) |=> !q.paired_en;
   endproperty
   a_rail_mask: assert property (p_rail_mask) else $error("unmasked rail ignored");

   property p_b1_mask;
      @(posedge CLK_I) disable iff (SRST_I) (!q.pg_s2.b1 && !q.pin[1]) |=> !q.paired_en;
   endproperty
   a_b1_mask: assert property (p_b1_mask) else $error("b1 good ignored");

   property p_pg_sel;
      @(posedge CLK_I) disable iff (SRST_I) 1'b1 |=> PAIRED_PG_SEL_O == $past(q.pin[6:5]);
   endproperty
   a_pg_sel: assert property (p_pg_sel) else $error("threshold select mismatch");

   property p_swap;
      @(posedge CLK_I) disable iff (SRST_I)
         SWAP_I |=> LDO1_EN_O == $past(q.paired_en) && SWB2_EN_O == $past(LDO1_LOGIC_EN_I);
   endproperty
   a_swap: assert property (p_swap) else $error("swap routing wrong");

   property p_b1_gate;
      @(posedge CLK_I) disable iff (SRST_I) !B1_PG_OK_I |=> !B1_EN_O;
   endproperty
   a_b1_gate: assert property (p_b1_gate) else $error("b1 on without goods");
endmodule

// ==== tb/lse_ctl_model.sv ====
`timescale 1ns/100ps
// ****************************************
// system controller side
// ****************************************
module lse_ctl_model (
   input wire logic clk_i, // bench clock
   input wire logic [5:0] ctl_req_i, // wanted control levels
   input wire logic [9:0] pg_req_i, // wanted power-good levels
   output logic [5:0] ctl_o, // control inputs to device
   output lse_pkg::lse_pg_t pg_o // power-good levels to device
);
   import lse_pkg::*;
   initial begin
      ctl_o = 6'h00;
      pg_o = 10'h000;
   end
   // levels move on the falling edge only, clear of device sampling
   always @(negedge clk_i) begin
      ctl_o <= ctl_req_i;
      pg_o <= pg_req_i;
   end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
module testbench;
   import lse_pkg::*;
   logic clk = 0, srst = 1, scl = 1, sda_m = 1;
   logic b1_sel = 0, b1_ok = 0, ldo1_log = 0, swap = 0;
   logic [5:0] ctl_req = 6'h00;
   logic [9:0] pg_req = 10'h000;
   logic [5:0] ctl;
   lse_pg_t pg;
   logic oe_n, b1_en, swb2_en, ldo1_en;
   logic [1:0] pg_sel;
   logic [7:0] rb;
   int failures = 0, n_compared = 0;
   // open drain data line with pull-up
   wire sda = sda_m & oe_n;
   lse_ctl_model u_ctl (.clk_i(clk), .ctl_req_i(ctl_req), .pg_req_i(pg_req), .ctl_o(ctl),
      .pg_o(pg));
   lse_top #(.CYC_PER_MS(10)) u_dut (.CLK_I(clk), .SRST_I(srst), .SCL_I(scl), .SDA_I(sda),
      .SDA_OE_N_O(oe_n), .CTL_I(ctl), .PG_I(pg), .B1_SEL_EN_I(b1_sel), .B1_PG_OK_I(b1_ok),
      .LDO1_LOGIC_EN_I(ldo1_log), .SWAP_I(swap), .B1_EN_O(b1_en), .SWB2_EN_O(swb2_en),
      .LDO1_EN_O(ldo1_en), .PAIRED_PG_SEL_O(pg_sel));
   initial begin
      forever #10 clk = ~clk;
   end
   // ****************************************
   // common tasks
   // ****************************************
   task automatic complete_run;
      if (failures == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic hp(input int n = 10);
      repeat (n) @(negedge clk);
   endtask
   task automatic start;
      sda_m = 1;
      scl = 1;
      hp();
      sda_m = 0;
      hp();
      scl = 0;
      hp();
   endtask
   task automatic stop;
      sda_m = 0;
      hp();
      scl = 1;
      hp();
      sda_m = 1;
      hp();
   endtask
   task automatic wbyte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sda_m = b[i];
         hp();
         scl = 1;
         hp();
         scl = 0;
      end
      sda_m = 1;
      hp();
      scl = 1;
      hp();
      chk("ack", sda, 8'h00);
      scl = 0;
      hp();
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      start();
      wbyte(8'h20);
      wbyte(a);
      wbyte(d);
      stop();
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      start();
      wbyte(8'h20);
      wbyte(a);
      start();
      wbyte(8'h21);
      for (int i = 7; i >= 0; i--) begin
         hp();
         scl = 1;
         hp();
         d[i] = sda;
         scl = 0;
      end
      hp();
      scl = 1;
      hp();
      scl = 0;
      hp();
      stop();
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      logic [7:0] ofs [4] = '{8'h24, 8'h25, 8'h26, 8'h30};
      wr(8'h30, 8'h5A);
      for (int i = 0; i < 4; i++) begin
         rd(ofs[i], rb);
         chk("reg", rb, 8'h00);
      end
      chk("pg sel", pg_sel, 8'h00);
      chk("paired en", swb2_en, 8'h00);
      chk("b1 en", b1_en, 8'h00);
   endtask
   task automatic t_source;
      logic [5:0] sel [8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0C, 6'h20, 6'h00};
      logic [7:0] v;
      wr(8'h25, 8'hFF);
      for (int c = 0; c < 8; c++) begin
         v = {1'b0, c[1:0], c[2:0], 2'b11};
         wr(8'h26, v);
         rd(8'h26, rb);
         chk("pin pg reg", rb, v);
         chk("pg sel", pg_sel, c[1:0]);
         ctl_req = sel[c];
         hp(8);
         chk("source on", swb2_en, 8'h01);
         ctl_req = (c == 5) ? 6'h37 : ~sel[c];
         hp(8);
         chk("source off", swb2_en, c == 7);
      end
      ctl_req = 6'h00;
   endtask
   task automatic t_mask;
      pg_req = 10'h3FF;
      wr(8'h25, 8'h00);
      wr(8'h26, 8'h1C);
      for (int i = 0; i < 10; i++) begin
         pg_req = 10'h3FF ^ (10'h001 << i);
         hp(8);
         chk("pg dropped", swb2_en, 8'h00);
         if (i < 2) wr(8'h26, 8'h1C | (8'h01 << i));
         else wr(8'h25, 8'h01 << (i - 2));
         hp(8);
         chk("pg masked", swb2_en, 8'h01);
         wr(8'h25, 8'h00);
         wr(8'h26, 8'h1C);
      end
      // later scenarios need every good back high
      pg_req = 10'h3FF;
      hp(8);
      chk("pg restored", swb2_en, 8'h01);
   endtask
   task automatic t_swap;
      swap = 1;
      hp(8);
      chk("swap ldo1", ldo1_en, 8'h01);
      chk("swap swb2", swb2_en, 8'h00);
      ldo1_log = 1;
      hp(8);
      chk("swap swb2", swb2_en, 8'h01);
      swap = 0;
      ldo1_log = 0;
      hp(8);
      chk("plain ldo1", ldo1_en, 8'h00);
      chk("plain swb2", swb2_en, 8'h01);
   endtask
   task automatic t_delay;
      int d [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
      int n;
      b1_ok = 1;
      for (int c = 0; c < 8; c++) begin
         wr(8'h24, {2'b00, 3'(7 - c), 3'(c)});
         for (int e = 1; e >= 0; e--) begin
            n = e ? d[c] : d[7 - c];
            b1_sel = e[0];
            if (n > 0) begin
               hp(n * 10 - 2);
               chk("b1 hold", b1_en, !e[0]);
            end
            hp(6);
            chk("b1 edge", b1_en, e[0]);
         end
      end
      wr(8'h24, 8'h00);
      b1_sel = 1;
      hp(3);
      b1_ok = 0;
      hp(3);
      chk("b1 goods", b1_en, 8'h00);
   endtask
   task automatic t_rereset;
      wr(8'h24, 8'h3F);
      wr(8'h25, 8'hA5);
      wr(8'h26, 8'h7C);
      b1_ok = 1;
      ldo1_log = 1;
      hp(4);
      chk("b1 en pre", b1_en, 8'h01);
      chk("pg sel pre", pg_sel, 8'h03);
      chk("ldo1 pre", ldo1_en, 8'h01);
      srst = 1;
      hp(2);
      chk("rst b1 en", b1_en, 8'h00);
      chk("rst swb2", swb2_en, 8'h00);
      chk("rst ldo1", ldo1_en, 8'h00);
      chk("rst pg sel", pg_sel, 8'h00);
      srst = 0;
      hp(6);
      // a surviving rise code of 111 would hold this off for 64 ms
      chk("rise code cleared", b1_en, 8'h01);
      chk("source cleared", swb2_en, 8'h00);
      chk("ldo1 after rst", ldo1_en, 8'h01);
      for (int i = 0; i < 3; i++) begin
         rd(8'h24 + 8'(i), rb);
         chk("reg after rst", rb, 8'h00);
      end
   endtask
   initial begin
      hp(2);
      srst = 0;
      hp(4);
      t_reset();
      t_source();
      t_mask();
      t_swap();
      t_delay();
      t_rereset();
      complete_run();
   end
   initial begin
      #1_500_000;
      failures++;
      complete_run();
   end
endmodule
